/* File: rtl/perf_threshold_monitor.sv */
// quarter-hour and day threshold monitor for one digital path
// assumes second/quarter-hour/day strobes are one-cycle pulses synchronous to clk_i;
// second classification comes with the second strobe
//
// Behaviour
// - without hysteresis, stamped report when a quarter-hour count first exceeds its limit.
// - quarter-hour counters keep counting after a crossing.
// - without hysteresis, log both quarter-hour counts at each period end.
// - errored clear level must not exceed errored limit; severe clear level is zero.
// - hysteresis: errored reports suppressed until period ends at or below clear level.
// - hysteresis: severe reports suppressed until period ends with zero severe count.
// - two day counters count errored and severe seconds, cleared each day.
// - day errored count over limit gives one stamped report per day.
// - day severe count over limit gives one stamped report per day.
// - quarter-hour counters cleared each period, counting errored and severe seconds.
// - path unavailable from the tenth consecutive severe second; evaluation off.
`timescale 1ns/1ps
`default_nettype none
module perf_threshold_monitor (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic second_tick_i,
	input wire logic errored_second_i,
	input wire logic severe_second_i,
	input wire logic quarter_hour_tick_i,
	input wire logic day_tick_i,
	input wire logic hysteresis_en_i,
	input wire perf_monitor_pkg::limits_t limits_i,
	input wire logic [perf_monitor_pkg::TIME_W-1:0] time_of_day_i,
	output logic report_valid_o,
	output perf_monitor_pkg::report_kind_t report_kind_o,
	output logic [perf_monitor_pkg::TIME_W-1:0] report_stamp_o,
	output logic log_valid_o,
	output perf_monitor_pkg::log_entry_t log_entry_o,
	output logic unavailable_o,
	output logic [perf_monitor_pkg::COUNT_W-1:0] quarter_hour_errored_count_o,
	output logic [perf_monitor_pkg::COUNT_W-1:0] quarter_hour_severe_count_o,
	output logic [perf_monitor_pkg::DAY_COUNT_W-1:0] day_errored_count_o,
	output logic [perf_monitor_pkg::DAY_COUNT_W-1:0] day_severe_count_o
);
	import perf_monitor_pkg::*;

	logic [COUNT_W-1:0] quarter_hour_errored_count;
	logic [COUNT_W-1:0] quarter_hour_severe_count;
	logic [DAY_COUNT_W-1:0] day_errored_count;
	logic [DAY_COUNT_W-1:0] day_severe_count;
	logic [3:0] severe_run;
	logic unavailable;
	logic count_en;
	logic qh_errored_hit;
	logic qh_severe_hit;
	logic qh_errored_held;
	logic qh_severe_held;
	logic day_errored_sent;
	logic day_severe_sent;
	logic qh_errored_over;
	logic qh_severe_over;
	logic day_errored_over;
	logic day_severe_over;
	logic qh_errored_fire;
	logic qh_severe_fire;
	logic qh_errored_clear_fire;
	logic qh_severe_clear_fire;
	logic day_errored_fire;
	logic day_severe_fire;
	logic [5:0] pending;
	logic [5:0] next_pending;
	report_kind_t next_kind;

	// onset of unavailability: 10th consecutive severe second; any other second ends it
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			severe_run <= 4'h0;
			unavailable <= 1'b0;
		end else if (second_tick_i) begin
			if (severe_second_i) begin
				if (severe_run == UNAVAIL_RUN_LAST) begin
					unavailable <= 1'b1;
				end else begin
					severe_run <= severe_run + 4'h1;
				end
			end else begin
				severe_run <= 4'h0;
				unavailable <= 1'b0;
			end
		end
	end

	// the seconds of a run that turns unavailable are counted before the onset is known;
	// we accept that small overcount instead of buffering ten seconds
	assign count_en = second_tick_i && !unavailable
		&& !(severe_second_i && severe_run == UNAVAIL_RUN_LAST);

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			quarter_hour_errored_count <= COUNT_RESET;
			quarter_hour_severe_count <= COUNT_RESET;
		end else if (quarter_hour_tick_i) begin
			quarter_hour_errored_count <= COUNT_RESET;
			quarter_hour_severe_count <= COUNT_RESET;
		end else if (count_en) begin
			// saturate; a crossing never freezes the counters
			if ((errored_second_i || severe_second_i) && ~&quarter_hour_errored_count) begin
				quarter_hour_errored_count <= quarter_hour_errored_count + 10'h001;
			end
			if (severe_second_i && ~&quarter_hour_severe_count) begin
				quarter_hour_severe_count <= quarter_hour_severe_count + 10'h001;
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			day_errored_count <= DAY_COUNT_RESET;
			day_severe_count <= DAY_COUNT_RESET;
		end else if (day_tick_i) begin
			day_errored_count <= DAY_COUNT_RESET;
			day_severe_count <= DAY_COUNT_RESET;
		end else if (count_en) begin
			if ((errored_second_i || severe_second_i) && ~&day_errored_count) begin
				day_errored_count <= day_errored_count + 17'h0_0001;
			end
			if (severe_second_i && ~&day_severe_count) begin
				day_severe_count <= day_severe_count + 17'h0_0001;
			end
		end
	end

	assign qh_errored_over = quarter_hour_errored_count > limits_i.quarter_hour_errored_limit;
	assign qh_severe_over = quarter_hour_severe_count > limits_i.quarter_hour_severe_limit;
	assign day_errored_over = day_errored_count > limits_i.day_errored_limit;
	assign day_severe_over = day_severe_count > limits_i.day_severe_limit;

	// one crossing report per period; in hysteresis mode the held flag also suppresses
	assign qh_errored_fire = qh_errored_over && !qh_errored_hit
		&& !(hysteresis_en_i && qh_errored_held);
	assign qh_severe_fire = qh_severe_over && !qh_severe_hit
		&& !(hysteresis_en_i && qh_severe_held);
	// clear levels are judged on the closing counts, on the boundary strobe
	// an errored clear level above the limit is a configuration fault left to software
	assign qh_errored_clear_fire = quarter_hour_tick_i && hysteresis_en_i && qh_errored_held
		&& quarter_hour_errored_count <= limits_i.quarter_hour_clear_level;
	assign qh_severe_clear_fire = quarter_hour_tick_i && hysteresis_en_i && qh_severe_held
		&& quarter_hour_severe_count == SEVERE_CLEAR_LEVEL;
	assign day_errored_fire = day_errored_over && !day_errored_sent;
	assign day_severe_fire = day_severe_over && !day_severe_sent;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			qh_errored_hit <= 1'b0;
			qh_severe_hit <= 1'b0;
		end else if (quarter_hour_tick_i) begin
			qh_errored_hit <= 1'b0;
			qh_severe_hit <= 1'b0;
		end else begin
			qh_errored_hit <= qh_errored_hit | qh_errored_over;
			qh_severe_hit <= qh_severe_hit | qh_severe_over;
		end
	end

	// hysteresis hold flags; a crossing in the same cycle as a clear wins
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			qh_errored_held <= 1'b0;
			qh_severe_held <= 1'b0;
		end else if (!hysteresis_en_i) begin
			qh_errored_held <= 1'b0;
			qh_severe_held <= 1'b0;
		end else begin
			if (qh_errored_fire) begin
				qh_errored_held <= 1'b1;
			end else if (qh_errored_clear_fire) begin
				qh_errored_held <= 1'b0;
			end
			if (qh_severe_fire) begin
				qh_severe_held <= 1'b1;
			end else if (qh_severe_clear_fire) begin
				qh_severe_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			day_errored_sent <= 1'b0;
			day_severe_sent <= 1'b0;
		end else if (day_tick_i) begin
			day_errored_sent <= 1'b0;
			day_severe_sent <= 1'b0;
		end else begin
			day_errored_sent <= day_errored_sent | day_errored_over;
			day_severe_sent <= day_severe_sent | day_severe_over;
		end
	end

	// several reports may fall due together; queue as flags, drain one per cycle by priority
	always_comb begin
		next_pending = pending | {day_severe_fire, day_errored_fire, qh_severe_clear_fire,
			qh_errored_clear_fire, qh_severe_fire, qh_errored_fire};
		next_kind = RPT_NONE;
		if (next_pending[0]) begin
			next_kind = RPT_QH_ERRORED;
			next_pending[0] = 1'b0;
		end else if (next_pending[1]) begin
			next_kind = RPT_QH_SEVERE;
			next_pending[1] = 1'b0;
		end else if (next_pending[2]) begin
			next_kind = RPT_QH_ERRORED_CLEAR;
			next_pending[2] = 1'b0;
		end else if (next_pending[3]) begin
			next_kind = RPT_QH_SEVERE_CLEAR;
			next_pending[3] = 1'b0;
		end else if (next_pending[4]) begin
			next_kind = RPT_DAY_ERRORED;
			next_pending[4] = 1'b0;
		end else if (next_pending[5]) begin
			next_kind = RPT_DAY_SEVERE;
			next_pending[5] = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pending <= 6'h00;
			report_valid_o <= 1'b0;
			report_kind_o <= RPT_NONE;
			report_stamp_o <= 32'h0000_0000;
		end else begin
			pending <= next_pending;
			report_valid_o <= (next_kind != RPT_NONE);
			report_kind_o <= next_kind;
			if (next_kind != RPT_NONE) begin
				report_stamp_o <= time_of_day_i;
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			log_valid_o <= 1'b0;
			log_entry_o <= '0;
		end else begin
			log_valid_o <= quarter_hour_tick_i && !hysteresis_en_i;
			if (quarter_hour_tick_i && !hysteresis_en_i) begin
				log_entry_o <= '{stamp: time_of_day_i,
					quarter_hour_errored_count: quarter_hour_errored_count,
					quarter_hour_severe_count: quarter_hour_severe_count};
			end
		end
	end

	assign unavailable_o = unavailable;
	assign quarter_hour_errored_count_o = quarter_hour_errored_count;
	assign quarter_hour_severe_count_o = quarter_hour_severe_count;
	assign day_errored_count_o = day_errored_count;
	assign day_severe_count_o = day_severe_count;
endmodule : perf_threshold_monitor
`default_nettype wire

/* File: rtl/perf_monitor_pkg.sv */
// package for the performance threshold monitor: widths, reset values, report codes
// assumes a single clock domain and period strobes generated elsewhere
package perf_monitor_pkg;
	localparam int COUNT_W = 10;
	localparam int DAY_COUNT_W = 17;
	localparam int TIME_W = 32;
	localparam int UNAVAIL_RUN = 10;
	localparam logic [3:0] UNAVAIL_RUN_LAST = 4'h9;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 10'h000;
	localparam logic [DAY_COUNT_W-1:0] DAY_COUNT_RESET = 17'h0_0000;
	localparam logic [COUNT_W-1:0] SEVERE_CLEAR_LEVEL = 10'h000;

	typedef enum logic [3:0] {
		RPT_NONE = 4'h0,
		RPT_QH_ERRORED = 4'h1,
		RPT_QH_SEVERE = 4'h2,
		RPT_QH_ERRORED_CLEAR = 4'h3,
		RPT_QH_SEVERE_CLEAR = 4'h4,
		RPT_DAY_ERRORED = 4'h5,
		RPT_DAY_SEVERE = 4'h6
	} report_kind_t;

	typedef struct packed {
		logic [COUNT_W-1:0] quarter_hour_errored_limit;
		logic [COUNT_W-1:0] quarter_hour_severe_limit;
		logic [COUNT_W-1:0] quarter_hour_clear_level;
		logic [DAY_COUNT_W-1:0] day_errored_limit;
		logic [DAY_COUNT_W-1:0] day_severe_limit;
	} limits_t;

	typedef struct packed {
		logic [TIME_W-1:0] stamp;
		logic [COUNT_W-1:0] quarter_hour_errored_count;
		logic [COUNT_W-1:0] quarter_hour_severe_count;
	} log_entry_t;
endpackage : perf_monitor_pkg

/* File: verification/perf_threshold_monitor_chk.sv */
// checker: counting, clearing, logging and outage relations
// assumes bind into perf_threshold_monitor; one clock, async low reset
`timescale 1ns/1ps
`default_nettype none
module perf_threshold_monitor_chk import perf_monitor_pkg::*; (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic second_tick_i,
	input wire logic errored_second_i,
	input wire logic severe_second_i,
	input wire logic quarter_hour_tick_i,
	input wire logic day_tick_i,
	input wire logic hysteresis_en_i,
	input wire logic report_valid_o,
	input wire logic log_valid_o,
	input wire logic unavailable_o,
	input wire logic [TIME_W-1:0] time_of_day_i,
	input wire logic [TIME_W-1:0] report_stamp_o,
	input wire report_kind_t report_kind_o,
	input wire log_entry_t log_entry_o,
	input wire logic [COUNT_W-1:0] quarter_hour_errored_count_o,
	input wire logic [COUNT_W-1:0] quarter_hour_severe_count_o,
	input wire logic [DAY_COUNT_W-1:0] day_errored_count_o,
	input wire logic [DAY_COUNT_W-1:0] day_severe_count_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	logic quiet;
	logic [3:0] run;
	assign quiet = !quarter_hour_tick_i && !day_tick_i;
	// saturates so a long outage never wraps back to nine
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) run <= 4'h0;
		else if (second_tick_i && quiet) run <= severe_second_i ? run + 4'(run != 4'hf) : 4'h0;
	end
	sequence s_err;
		second_tick_i && errored_second_i && !severe_second_i && quiet && !unavailable_o;
	endsequence
	sequence s_down_sev;
		unavailable_o && second_tick_i && severe_second_i && quiet;
	endsequence
	property p_count;
		s_err |=> quarter_hour_errored_count_o == $past(quarter_hour_errored_count_o) + 10'h001;
	endproperty
	a_count: assert property (p_count) else $error("second not counted");
	property p_down_hold;
		s_down_sev |=> $stable(quarter_hour_severe_count_o) && $stable(day_severe_count_o);
	endproperty
	a_down_hold: assert property (p_down_hold) else $error("counted while down");
	property p_down_set;
		second_tick_i && severe_second_i && quiet && run == 4'h9 |=> unavailable_o;
	endproperty
	a_down_set: assert property (p_down_set) else $error("outage not entered");
	property p_qh_clear;
		quarter_hour_tick_i |=> quarter_hour_errored_count_o == COUNT_RESET
			&& quarter_hour_severe_count_o == COUNT_RESET;
	endproperty
	a_qh_clear: assert property (p_qh_clear) else $error("period count kept");
	property p_day_clear;
		day_tick_i |=> day_errored_count_o == DAY_COUNT_RESET && day_severe_count_o == 17'h0_0000;
	endproperty
	a_day_clear: assert property (p_day_clear) else $error("day count kept");
	property p_log_follow;
		quarter_hour_tick_i && !hysteresis_en_i |=> log_valid_o;
	endproperty
	a_log_follow: assert property (p_log_follow) else $error("log missing");
	property p_log_cause;
		log_valid_o |-> $past(quarter_hour_tick_i) && !$past(hysteresis_en_i);
	endproperty
	a_log_cause: assert property (p_log_cause) else $error("stray log");
	// the log carries the closing counts, taken on the boundary strobe before clearing
	property p_log_entry;
		log_valid_o |-> log_entry_o.stamp == $past(time_of_day_i)
			&& log_entry_o.quarter_hour_errored_count == $past(quarter_hour_errored_count_o)
			&& log_entry_o.quarter_hour_severe_count == $past(quarter_hour_severe_count_o);
	endproperty
	a_log_entry: assert property (p_log_entry) else $error("log entry mismatch");
	property p_stamp;
		report_valid_o |-> report_stamp_o == $past(time_of_day_i) && report_kind_o != RPT_NONE;
	endproperty
	a_stamp: assert property (p_stamp) else $error("bad report stamp");
endmodule : perf_threshold_monitor_chk
bind perf_threshold_monitor perf_threshold_monitor_chk chk (.*);
`default_nettype wire

/* File: verification/mgmt_sink.sv */
// management model: tallies reports by kind, keeps a path state
// assumes one-cycle report pulses on the monitor clock
`timescale 1ns/1ps
`default_nettype none
module mgmt_sink import perf_monitor_pkg::*; (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic report_valid_i,
	input wire report_kind_t report_kind_i,
	output logic [7:0] tally_o [0:6],
	output logic [1:0] path_state_o
);
	// mapping is ours: severe is worst, clears restore normal
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tally_o <= '{default: 8'h00};
			path_state_o <= 2'h0;
		end else if (report_valid_i) begin
			tally_o[report_kind_i] <= tally_o[report_kind_i] + 8'h01;
			path_state_o <= report_kind_i inside {RPT_QH_SEVERE, RPT_DAY_SEVERE} ? 2'h2 :
				2'(report_kind_i inside {RPT_QH_ERRORED, RPT_DAY_ERRORED});
		end
	end
endmodule : mgmt_sink
`default_nettype wire

/* File: verification/perf_threshold_monitor_bench.sv */
// bench: random seconds and period ticks against a reference model
// assumes package, design, checker and mgmt_sink compiled first
`timescale 1ns/1ps
`default_nettype none
module perf_threshold_monitor_bench;
	import perf_monitor_pkg::*;
	logic clk_i = 1'b0, nrst_i = 1'b0, sec = 1'b0, err = 1'b0, sev = 1'b0;
	logic qt = 1'b0, dt = 1'b0, hy = 1'b0, rv, lv, un;
	limits_t lim = '0;
	logic [TIME_W-1:0] tod = '0, rs;
	report_kind_t rk;
	log_entry_t le;
	logic [COUNT_W-1:0] qe_o, qs_o;
	logic [DAY_COUNT_W-1:0] de_o, ds_o;
	logic [7:0] tally [0:6];
	int n_errors = 0, tests_run = 0, qe, qs, de, ds, run, ex [7];
	bit f [7], down;
	perf_threshold_monitor dut (.clk_i(clk_i), .nrst_i(nrst_i), .second_tick_i(sec),
		.errored_second_i(err), .severe_second_i(sev), .quarter_hour_tick_i(qt),
		.day_tick_i(dt), .hysteresis_en_i(hy), .limits_i(lim), .time_of_day_i(tod),
		.report_valid_o(rv), .report_kind_o(rk), .report_stamp_o(rs), .log_valid_o(lv),
		.log_entry_o(le), .unavailable_o(un), .quarter_hour_errored_count_o(qe_o),
		.quarter_hour_severe_count_o(qs_o), .day_errored_count_o(de_o),
		.day_severe_count_o(ds_o));
	mgmt_sink sink (.clk_i(clk_i), .nrst_i(nrst_i), .report_valid_i(rv),
		.report_kind_i(rk), .tally_o(tally), .path_state_o());
	initial forever #50 clk_i = ~clk_i;
	always @(posedge clk_i) tod <= $urandom;
	task automatic check(string name, logic [63:0] seen, logic [63:0] want);
		tests_run++;
		if (seen !== want) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", name, want, seen);
		end
	endtask : check
	task automatic conclude();
		if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	task automatic rst(bit h);
		logic [9:0] l;
		l = 10'(2 + $urandom % 4);
		@(posedge clk_i) nrst_i <= 1'b0;
		hy <= h;
		lim <= {l, 10'(1 + $urandom % 3), 10'($urandom % (l + 1)),
			17'(8 + $urandom % 8), 17'(4 + $urandom % 4)};
		repeat (12) @(posedge clk_i);
		nrst_i <= 1'b1;
		{qe, qs, de, ds, run} = '0;
		down = 1'b0;
		f = '{default: 0};
		ex = '{default: 0};
	endtask : rst
	function automatic void rpt(int k, bit over);
		if (over && !f[k]) begin
			f[k] = 1;
			ex[k]++;
		end
	endfunction : rpt
	task automatic second(bit e, bit s);
		bit was;
		was = down;
		@(posedge clk_i) {sec, err, sev} <= {1'b1, e, s};
		@(posedge clk_i) sec <= 1'b0;
		run = s ? run + 1 : 0;
		down = run >= 10 || (down && s);
		if (!down && !was) begin
			qe += e | s;
			qs += s;
			de += e | s;
			ds += s;
		end
		rpt(1, qe > lim.quarter_hour_errored_limit);
		rpt(2, qs > lim.quarter_hour_severe_limit);
		rpt(5, de > lim.day_errored_limit);
		rpt(6, ds > lim.day_severe_limit);
		#1;
		check("unavailable", un, down);
		if (!was) check("counts", {qe_o, qs_o, de_o, ds_o},
			{10'(qe), 10'(qs), 17'(de), 17'(ds)});
		repeat (8) @(posedge clk_i);
	endtask : second
	task automatic tick(bit day);
		@(posedge clk_i) {qt, dt} <= {!day, day};
		@(posedge clk_i) {qt, dt} <= 2'b00;
		#1;
		check("log_valid", lv, !day && !hy);
		if (!day && !hy) check("log", le[19:0], {10'(qe), 10'(qs)});
		if (day) begin
			{f[5], f[6]} = 2'b00;
			{de, ds} = '0;
		end else begin
			// hysteresis holds the flag until a period closing at or below the clear level (zero severe for severe) sends the clear
			if (hy && f[1] && qe <= lim.quarter_hour_clear_level) ex[3]++;
			if (hy && f[2] && qs == 0) ex[4]++;
			f[1] = f[1] && hy && qe > lim.quarter_hour_clear_level;
			f[2] = f[2] && hy && qs != 0;
			{qe, qs} = '0;
		end
		repeat (8) @(posedge clk_i);
		for (int k = 1; k < 7; k++) check("reports", tally[k], ex[k]);
	endtask : tick
	initial begin
		void'($urandom(32'h85c4_60de));
		for (int h = 0; h < 2; h++) begin
			rst(h[0]);
			for (int p = 0; p < 6; p++) begin
				repeat (p == 0 ? lim.quarter_hour_errored_limit + 1 : p % 2 * 12)
					second(p == 0 || $urandom % 2 == 1, p != 0 && $urandom % 3 == 0);
				tick(0);
			end
			tick(1);
			repeat (11) second(1, 1);
			second(0, 0);
			tick(0);
			tick(1);
		end
		conclude();
	end
	initial begin
		#2_000_000;
		n_errors++;
		conclude();
	end
endmodule : perf_threshold_monitor_bench
`default_nettype wire
